// ---- module_ctrl_pkg.sv ----
package module_ctrl_pkg;

   // ----------------------------------------------------------------
   // clock and documented times
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 50;
   localparam int unsigned T_MASK_ON_MS   = 100;
   localparam int unsigned T_MASK_OFF_MS  = 100;
   localparam int unsigned T_SEL_ON_US    = 100;
   localparam int unsigned T_SEL_OFF_US   = 100;
   localparam int unsigned T_PDOWN_ON_MS  = 100;
   localparam int unsigned T_PDOWN_OFF_MS = 300;
   localparam int unsigned T_FLAG_ON_MS   = 200;
   localparam int unsigned T_INT_OFF_US   = 500;
   localparam int unsigned T_RESET_MIN_NS = 2000;
   localparam int unsigned T_INIT_MS      = 2000;

   // longest times round down, least times round up
   localparam int unsigned MASK_ON_CYC   = T_MASK_ON_MS * CLK_MHZ * 1000;
   localparam int unsigned MASK_OFF_CYC  = T_MASK_OFF_MS * CLK_MHZ * 1000;
   localparam int unsigned SEL_ON_CYC    = T_SEL_ON_US * CLK_MHZ;
   localparam int unsigned SEL_OFF_CYC   = T_SEL_OFF_US * CLK_MHZ;
   localparam int unsigned PDOWN_ON_CYC  = T_PDOWN_ON_MS * CLK_MHZ * 1000;
   localparam int unsigned PDOWN_OFF_CYC = T_PDOWN_OFF_MS * CLK_MHZ * 1000;
   localparam int unsigned FLAG_ON_CYC   = T_FLAG_ON_MS * CLK_MHZ * 1000;
   localparam int unsigned INT_OFF_CYC   = T_INT_OFF_US * CLK_MHZ;
   localparam int unsigned RESET_MIN_CYC =
      (T_RESET_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned INIT_CYC      = T_INIT_MS * CLK_MHZ * 1000;
   localparam int unsigned RST_CNT_W     = 8;

   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W    = 5;
   localparam int unsigned FLAG_W    = 8;
   localparam int unsigned IRQ_W     = 3;
   localparam logic [4:0] ADDR_CTRL     = 5'h00;
   localparam logic [4:0] ADDR_MASK     = 5'h04;
   localparam logic [4:0] ADDR_FLAGS    = 5'h08;
   localparam logic [4:0] ADDR_STATUS   = 5'h0c;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h14;

   // field positions
   localparam int unsigned CTRL_PDOWN_BIT  = 0;
   localparam int unsigned FLAG_READY_BIT  = 0;
   localparam int unsigned ST_DNR_BIT      = 0;
   localparam int unsigned ST_SERIAL_BIT   = 1;
   localparam int unsigned ST_LOWPWR_BIT   = 2;
   localparam int unsigned ST_LASER_BIT    = 3;
   localparam int unsigned ST_ARMED_BIT    = 4;
   localparam int unsigned IRQ_COMMIT_BIT  = 0;
   localparam int unsigned IRQ_MODRST_BIT  = 1;
   localparam int unsigned IRQ_SELCHG_BIT  = 2;

   // reset values
   localparam logic [7:0] MASK_RST     = 8'h00;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // pin synchroniser order and idle levels
   localparam int unsigned PIN_W   = 6;
   localparam int unsigned P_SCL   = 0;
   localparam int unsigned P_SDA   = 1;
   localparam int unsigned P_SEL_N = 2;
   localparam int unsigned P_RST_N = 3;
   localparam int unsigned P_LPSEL = 4;
   localparam int unsigned P_TRANSMIT_DISABLE  = 5;
   localparam logic [5:0] PIN_IDLE = 6'h2f;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
   parameter int unsigned W        = 1,
   parameter logic [W-1:0] IDLE    = '0
) (
   input  wire logic         clk_i,
   input  wire logic         reset_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = pin_i;
      sync_d = meta_q;
   end

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         meta_q <= IDLE;
         sync_q <= IDLE;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_o = sync_q;

endmodule

// ---- module_soft_control.sv ----
// Contract
// - setting a mask bit stops the interrupt for that flag within 100 ms
// - clearing a mask bit resumes the interrupt for that flag in 100 ms
// - select asserted, serial responses begin within 100 us
// - select deasserted, serial responses stop within 100 us
// - power-down override set enters low power within 100 ms
// - power-down override cleared returns fully functional within 300 ms
// - fully functional means not-ready cleared and interrupt asserted for it; power-down release here raises no interrupt
// - write-triggered latencies start at clock fall after write stop
// - read-triggered latencies start at clock fall after read stop
// - transmit disable high or open turns laser off, low turns it on
// - flag condition sets its flag and interrupt within 200 ms
// - flags clear on read; interrupt releases within 500 us
// - module reset only after reset pin low beyond 2 us
// - after power-on, not-ready clears and interrupt asserts in 2000 ms
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module module_soft_control
   import module_ctrl_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = INIT_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic [ADDR_W-1:0] address_i,
   input  wire logic              read_i,
   input  wire logic              write_i,
   input  wire logic [31:0]       writedata_i,
   input  wire logic [3:0]        byteenable_i,
   output logic      [31:0]       readdata_o,
   output logic                   waitrequest_o,
   output logic                   irq_o,
   input  wire logic              module_select_n_i,
   input  wire logic              module_reset_n_i,
   input  wire logic              low_power_select_i,
   input  wire logic              transmit_disable_i,
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   input  wire logic [FLAG_W-1:1] flag_event_i,
   output logic                   interrupt_out_n_o,
   output logic                   module_present_n_o,
   output logic                   serial_enable_o,
   output logic                   low_power_o,
   output logic                   laser_enable_o,
   output logic                   data_not_ready_o
);

   localparam logic [RST_CNT_W-1:0] RST_LIMIT = RST_CNT_W'(RESET_MIN_CYC);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pin_s;

   pin_sync #(
      .W    (PIN_W),
      .IDLE (PIN_IDLE)
   ) u_pin_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   ({transmit_disable_i, low_power_select_i, module_reset_n_i,
                 module_select_n_i, sda_i, scl_i}),
      .sync_o  (pin_s)
   );

   // ----------------------------------------------------------------
   // serial commit point: clock fall after a stop
   // ----------------------------------------------------------------
   logic scl_prev_q, scl_prev_d;
   logic sda_prev_q, sda_prev_d;
   logic armed_q, armed_d;
   logic stop_seen;
   logic commit;

   always_comb begin
      scl_prev_d = pin_s[P_SCL];
      sda_prev_d = pin_s[P_SDA];
      stop_seen  = pin_s[P_SCL] & scl_prev_q & pin_s[P_SDA] & ~sda_prev_q;
      commit     = armed_q & scl_prev_q & ~pin_s[P_SCL];
      armed_d    = armed_q;
      if (stop_seen) begin
         armed_d = 1'b1;
      end else if (commit) begin
         armed_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         armed_q    <= 1'b0;
      end else begin
         scl_prev_q <= scl_prev_d;
         sda_prev_q <= sda_prev_d;
         armed_q    <= armed_d;
      end
   end

   // ----------------------------------------------------------------
   // module reset pulse filter and initialisation
   // ----------------------------------------------------------------
   logic [RST_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
   logic [31:0]          init_cnt_q, init_cnt_d;
   logic                 dnr_q, dnr_d;
   logic                 in_reset;
   logic                 ready_evt;

   always_comb begin
      in_reset   = (rst_cnt_q == RST_LIMIT);
      rst_cnt_d  = rst_cnt_q;
      if (pin_s[P_RST_N]) begin
         rst_cnt_d = '0;
      end else if (!in_reset) begin
         rst_cnt_d = rst_cnt_q + 1'b1;
      end
      ready_evt  = 1'b0;
      dnr_d      = dnr_q;
      init_cnt_d = init_cnt_q;
      if (in_reset) begin
         dnr_d      = 1'b1;
         init_cnt_d = '0;
      end else if (dnr_q) begin
         if (init_cnt_q == INIT_CYCLES - 1) begin
            dnr_d     = 1'b0;
            ready_evt = 1'b1;
         end else begin
            init_cnt_d = init_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rst_cnt_q  <= '0;
         init_cnt_q <= '0;
         dnr_q      <= 1'b1;
      end else begin
         rst_cnt_q  <= rst_cnt_d;
         init_cnt_q <= init_cnt_d;
         dnr_q      <= dnr_d;
      end
   end

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle per access
   // ----------------------------------------------------------------
   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic        rd_done, wr_done;
   logic [FLAG_W-1:0] mask_pend_q, mask_pend_d, mask_q, mask_d;
   logic [FLAG_W-1:0] flag_q, flag_d, clr_pend_q, clr_pend_d, set_vec;
   logic        pdown_pend_q, pdown_pend_d, pdown_q, pdown_d;
   logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
   logic [IRQ_W-1:0] irq_set;
   logic        serial_en_q, low_power_q, laser_en_q, int_n_q, irq_q;
   logic [31:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[ST_DNR_BIT]    = dnr_q;
      status_word[ST_SERIAL_BIT] = serial_en_q;
      status_word[ST_LOWPWR_BIT] = low_power_q;
      status_word[ST_LASER_BIT]  = laser_en_q;
      status_word[ST_ARMED_BIT]  = armed_q;
      wr_done = write_i & ~wait_q & byteenable_i[0];
      rd_done = read_i & ~wait_q;
      wait_d  = ~((read_i | write_i) & wait_q);
      rdata_d = rdata_q;
      if (read_i && wait_q) begin
         unique case (address_i)
            ADDR_CTRL:     rdata_d = {31'h0, pdown_pend_q};
            ADDR_MASK:     rdata_d = {24'h0, mask_pend_q};
            ADDR_FLAGS:    rdata_d = {24'h0, flag_q};
            ADDR_STATUS:   rdata_d = status_word;
            ADDR_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
            ADDR_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
            default:       rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // soft controls and flags
   // ----------------------------------------------------------------
   // mask and power-down writes wait for the commit point, so latency counts from there; irq mask writes act at once
   always_comb begin
      mask_pend_d  = mask_pend_q;
      pdown_pend_d = pdown_pend_q;
      irq_mask_d   = irq_mask_q;
      if (wr_done && address_i == ADDR_MASK) begin
         mask_pend_d = writedata_i[FLAG_W-1:0];
      end
      if (wr_done && address_i == ADDR_CTRL) begin
         pdown_pend_d = writedata_i[CTRL_PDOWN_BIT];
      end
      if (wr_done && address_i == ADDR_IRQ_MASK) begin
         irq_mask_d = writedata_i[IRQ_W-1:0];
      end
      mask_d  = commit ? mask_pend_q : mask_q;
      pdown_d = commit ? pdown_pend_q : pdown_q;
      set_vec = {flag_event_i, ready_evt};
      clr_pend_d = commit ? '0 : clr_pend_q;
      // clear only what the host saw; a flag set during the access stays
      if (rd_done && address_i == ADDR_FLAGS) begin
         clr_pend_d = clr_pend_d | rdata_q[FLAG_W-1:0];
      end
      // a new event beats a clear landing in the same cycle
      flag_d = (commit ? (flag_q & ~clr_pend_q) : flag_q) | set_vec;
      if (in_reset) begin
         flag_d     = '0;
         clr_pend_d = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mask_pend_q  <= MASK_RST;
         mask_q       <= MASK_RST;
         pdown_pend_q <= 1'b0;
         pdown_q      <= 1'b0;
         clr_pend_q   <= '0;
         flag_q       <= '0;
         irq_mask_q   <= IRQ_MASK_RST;
      end else begin
         mask_pend_q  <= mask_pend_d;
         mask_q       <= mask_d;
         pdown_pend_q <= pdown_pend_d;
         pdown_q      <= pdown_d;
         clr_pend_q   <= clr_pend_d;
         flag_q       <= flag_d;
         irq_mask_q   <= irq_mask_d;
      end
   end

   // ----------------------------------------------------------------
   // local interrupt status, clear on read
   // ----------------------------------------------------------------
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_COMMIT_BIT] = commit;
      irq_set[IRQ_MODRST_BIT] = (rst_cnt_q == RST_LIMIT - 1'b1) &
                                ~pin_s[P_RST_N];
      irq_set[IRQ_SELCHG_BIT] = serial_en_q == pin_s[P_SEL_N];
      irq_stat_d = irq_stat_q;
      if (rd_done && address_i == ADDR_IRQ_STAT) begin
         irq_stat_d = '0;
      end
      irq_stat_d = irq_stat_d | irq_set;
   end

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         irq_stat_q  <= '0;
         irq_q       <= 1'b0;
         serial_en_q <= 1'b0;
         low_power_q <= 1'b0;
         laser_en_q  <= 1'b0;
         int_n_q     <= 1'b1;
      end else begin
         irq_stat_q  <= irq_stat_d;
         irq_q       <= |(irq_stat_q & irq_mask_q);
         serial_en_q <= ~pin_s[P_SEL_N] & ~in_reset;
         low_power_q <= pin_s[P_LPSEL] | pdown_q;
         laser_en_q  <= ~pin_s[P_TRANSMIT_DISABLE];
         int_n_q     <= ~|(flag_q & ~mask_q);
      end
   end

   assign readdata_o         = rdata_q;
   assign waitrequest_o      = wait_q;
   assign irq_o              = irq_q;
   assign interrupt_out_n_o  = int_n_q;
   assign module_present_n_o = 1'b0;
   assign serial_enable_o    = serial_en_q;
   assign low_power_o        = low_power_q;
   assign laser_enable_o     = laser_en_q;
   assign data_not_ready_o   = dnr_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_mask_inhibit: assert property (
      commit ##1 ((flag_q & ~mask_q) == '0) |=> int_n_q)
      else $error("masked flags still drive interrupt");
   a_mask_resume: assert property (
      commit ##1 ((flag_q & ~mask_q) != '0) |=> !int_n_q)
      else $error("unmasked flag fails to drive interrupt");
   a_select_on: assert property (
      (!module_select_n_i && !in_reset)[*4] |-> serial_en_q)
      else $error("serial responses not enabled after select");
   a_select_off: assert property (
      module_select_n_i[*4] |-> !serial_en_q)
      else $error("serial responses still enabled after deselect");
   a_pdown_enter: assert property (
      commit && pdown_pend_q |-> ##2 low_power_q)
      else $error("power-down override did not lower power");
   a_pdown_leave: assert property (
      commit && !pdown_pend_q ##1 !pin_s[P_LPSEL] |=> !low_power_q)
      else $error("power-down release did not restore power");
   a_ready_irq: assert property (
      $fell(dnr_q) |-> flag_q[FLAG_READY_BIT] ##1
         (mask_q[FLAG_READY_BIT] || !int_n_q))
      else $error("ready transition did not raise interrupt");
   a_mask_hold: assert property (
      !commit |=> $stable(mask_q) && $stable(pdown_q))
      else $error("control changed outside commit point");
   a_flag_keep: assert property (
      !commit && !in_reset |=> (flag_q & $past(flag_q)) == $past(flag_q))
      else $error("flag cleared outside commit point");
   a_laser_off: assert property (
      transmit_disable_i[*4] |-> !laser_en_q)
      else $error("laser enabled while transmit disabled");
   a_flag_set: assert property (
      (flag_event_i != '0) && !in_reset |=>
         (flag_q[FLAG_W-1:1] & $past(flag_event_i)) == $past(flag_event_i))
      else $error("flag condition not latched");
   a_int_release: assert property (
      commit && ((flag_q & ~clr_pend_q & ~mask_pend_q) == '0) &&
         set_vec == '0 ##1 set_vec == '0 |=> int_n_q)
      else $error("interrupt not released after clear on read");
   a_reset_short: assert property (
      $rose(in_reset) |-> !$past(pin_s[P_RST_N], 2))
      else $error("module reset without long enough pulse");
   a_init_time: assert property (
      $fell(dnr_q) && !$past(in_reset) |->
         $past(init_cnt_q) == INIT_CYCLES - 1)
      else $error("not-ready cleared at wrong time");

   c_commit_mask: cover property (commit && mask_pend_q != mask_q);
   c_clear_read: cover property (commit && clr_pend_q != '0);
   c_mod_reset: cover property ($rose(in_reset));
   c_ready: cover property ($fell(dnr_q));

endmodule

// ---- host_serial_model.sv ----
`timescale 1ns/100ps
module host_serial_model (
   output logic scl_o,
   output logic sda_o
);

   // ----------------------------------------------------------
   // 2-wire host, 160 ns bus clock, still between frames
   // ----------------------------------------------------------
   localparam int HALF_NS = 80;

   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic bit_out(input logic b);
      sda_o = b;
      #(HALF_NS / 2);
      scl_o = 1'b1;
      #(HALF_NS);
      scl_o = 1'b0;
      #(HALF_NS / 2);
   endtask

   task automatic frame(input logic [7:0] b);
      // odd offset keeps the bus unrelated to the block clock
      #7;
      sda_o = 1'b0;
      #(HALF_NS);
      scl_o = 1'b0;
      #(HALF_NS / 2);
      for (int i = 7; i >= 0; i--) begin
         bit_out(b[i]);
      end
      // ack slot: line released, pull-up holds it high
      bit_out(1'b1);
      sda_o = 1'b0;
      #(HALF_NS / 2);
      scl_o = 1'b1;
      #(HALF_NS);
      sda_o = 1'b1;
      #(HALF_NS);
   endtask

endmodule

// ---- module_soft_control_tb.sv ----
`timescale 1ns/100ps
module module_soft_control_tb
   import module_ctrl_pkg::*;
();

   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   localparam int INIT_N = 50;
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic [4:0]  addr    = 5'h00;
   logic        rd      = 1'b0;
   logic        wr      = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  be      = 4'hf;
   logic        sel_n   = 1'b1;
   logic        mrst_n  = 1'b1;
   logic        lp_sel  = 1'b0;
   logic        transmit_disable    = 1'b1;
   logic [7:1]  flag_ev = 7'h00;
   logic [31:0] rdata, rv;
   logic        wait_req, irq, int_n, prs_n;
   logic        ser_en, low_pw, laser, dnr, scl, sda;
   int          bad_count    = 0;
   int          total_checks = 0;

   always #10 clk = ~clk;

   module_soft_control #(.INIT_CYCLES(INIT_N)) u_dut (
      .clk_i(clk), .reset_i(rst), .address_i(addr), .read_i(rd),
      .write_i(wr), .writedata_i(wdata), .byteenable_i(be),
      .readdata_o(rdata), .waitrequest_o(wait_req), .irq_o(irq),
      .module_select_n_i(sel_n), .module_reset_n_i(mrst_n),
      .low_power_select_i(lp_sel), .transmit_disable_i(transmit_disable),
      .scl_i(scl), .sda_i(sda), .flag_event_i(flag_ev),
      .interrupt_out_n_o(int_n), .module_present_n_o(prs_n),
      .serial_enable_o(ser_en), .low_power_o(low_pw),
      .laser_enable_o(laser), .data_not_ready_o(dnr)
   );

   host_serial_model u_host (.scl_o(scl), .sda_o(sda));

   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task check_bit(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task check_word(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // waitrequest is a register: its level at the falling edge is
   // what the next rising edge samples
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
            input logic [3:0] b);
      @(posedge clk);
      addr  <= a;
      wr    <= w;
      rd    <= !w;
      wdata <= d;
      be    <= b;
      do begin
         @(negedge clk);
      end while (wait_req !== 1'b0);
      @(posedge clk);
      rv = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task wr32(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task rd_chk(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      check_word(rv, e);
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wait_dnr(input int lim);
      int n;
      n = 0;
      while (dnr !== 1'b0 && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask

   // mask and power-down writes and flag reads only act at the scl fall after a stop
   task commit;
      u_host.frame(8'ha0);
      u_host.frame(8'ha1);
      cyc(2);
   endtask

   // ----------------------------------------------------------
   // tests
   // ----------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      cyc(1);
      check_bit(int_n, 1'b1);
      check_bit(prs_n, 1'b0);
      check_bit(wait_req, 1'b1);
      check_bit(dnr, 1'b1);
      rd_chk(ADDR_MASK, {24'h0, MASK_RST});
      rd_chk(ADDR_IRQ_MASK, {29'h0, IRQ_MASK_RST});
      wr32(5'h18, 32'hff);
      rd_chk(5'h18, 32'h0);
      wait_dnr(INIT_N + 50);
      check_bit(dnr, 1'b0);
      cyc(3);
      check_bit(int_n, 1'b0);
      rd_chk(ADDR_FLAGS, 32'h1);
      cyc(3);
      check_bit(int_n, 1'b0);
      commit;
      check_bit(int_n, 1'b1);
      @(posedge clk);
      flag_ev <= 7'h04;
      @(posedge clk);
      flag_ev <= 7'h00;
      cyc(3);
      check_bit(int_n, 1'b0);
      wr32(ADDR_MASK, 32'h08);
      bus(1'b1, ADDR_MASK, 32'h0, 4'he);
      cyc(3);
      check_bit(int_n, 1'b0);
      commit;
      check_bit(int_n, 1'b1);
      wr32(ADDR_MASK, 32'h0);
      commit;
      check_bit(int_n, 1'b0);
      rd_chk(ADDR_FLAGS, 32'h08);
      commit;
      check_bit(int_n, 1'b1);
      wr32(ADDR_CTRL, 32'h1);
      commit;
      check_bit(low_pw, 1'b1);
      rd_chk(ADDR_STATUS, 32'h14);
      wr32(ADDR_CTRL, 32'h0);
      commit;
      check_bit(low_pw, 1'b0);
      check_bit(dnr, 1'b0);
      @(posedge clk);
      transmit_disable <= 1'b0;
      cyc(5);
      check_bit(laser, 1'b1);
      @(posedge clk);
      transmit_disable <= 1'b1;
      cyc(5);
      check_bit(laser, 1'b0);
      rd_chk(ADDR_IRQ_STAT, 32'h1);
      @(posedge clk);
      sel_n <= 1'b0;
      cyc(5);
      check_bit(ser_en, 1'b1);
      check_bit(irq, 1'b0);
      wr32(ADDR_IRQ_MASK, 32'h4);
      cyc(2);
      check_bit(irq, 1'b1);
      rd_chk(ADDR_IRQ_STAT, 32'h4);
      cyc(3);
      check_bit(irq, 1'b0);
      @(posedge clk);
      sel_n <= 1'b1;
      cyc(5);
      check_bit(ser_en, 1'b0);
      // a pulse below the minimum width must be ignored
      @(posedge clk);
      mrst_n <= 1'b0;
      repeat (50) @(posedge clk);
      mrst_n <= 1'b1;
      cyc(3);
      check_bit(dnr, 1'b0);
      @(posedge clk);
      mrst_n <= 1'b0;
      repeat (RESET_MIN_CYC + 10) @(posedge clk);
      cyc(1);
      check_bit(dnr, 1'b1);
      @(posedge clk);
      mrst_n <= 1'b1;
      wait_dnr(INIT_N + 50);
      check_bit(dnr, 1'b0);
      cyc(3);
      check_bit(int_n, 1'b0);
      rd_chk(ADDR_IRQ_STAT, 32'h6);
      end_of_test;
   end

   initial begin
      #500us;
      bad_count++;
      end_of_test;
   end

endmodule
